// *** rtl/host_packet_framer.sv ***
// Purpose: packet framing between display module core and host serial link
// Assumes: inputs synchronous to REF_CLK_I; core answers each command in time
// Notes: rx packets checked then handed to core; tx packets built from core
`timescale 1ns/10ps

// ------------------------------------------------------------
// fifo
// ------------------------------------------------------------
module pkt_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
   logic [AW:0] cnt_reg, cnt_next;
   logic push, pop;

   assign in_ready_o = (cnt_reg != (AW+1)'(DEPTH));
   assign out_valid_o = (cnt_reg != '0);
   assign out_data_o = mem_reg[rd_reg];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   always_comb begin
      wr_next = push ? AW'(wr_reg + 1'b1) : wr_reg;
      rd_next = pop ? AW'(rd_reg + 1'b1) : rd_reg;
      cnt_next = (AW+1)'(cnt_reg + push - pop);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
      end else begin
         wr_reg <= wr_next;
         rd_reg <= rd_next;
         cnt_reg <= cnt_next;
      end
      if (push) begin
         mem_reg[wr_reg] <= in_data_i;
      end
   end
endmodule

// ------------------------------------------------------------
// framer top
// ------------------------------------------------------------
module host_packet_framer #(
   parameter logic [15:0] CRC_POLY = host_packet_framer_pkg::CRC_POLY_DEF,
   parameter logic [15:0] CRC_INIT = host_packet_framer_pkg::CRC_INIT_DEF,
   parameter logic CRC_INV = host_packet_framer_pkg::CRC_INV_DEF,
   parameter longint ACK_CYCLES = host_packet_framer_pkg::ACK_CYC
) (
   input wire logic REF_CLK_I,
   input wire logic SYS_RST_I,
   input wire logic RXD_I,
   output logic TXD_O,
   input wire logic FAST_BAUD_REQ_I,
   output logic FAST_BAUD_O,
   output logic RX_VALID_O,
   output logic [7:0] RX_DATA_O,
   output logic RX_FIRST_O,
   output logic RX_LAST_O,
   input wire logic RX_READY_I,
   input wire logic TX_VALID_I,
   input wire logic [7:0] TX_DATA_I,
   output logic TX_READY_O,
   input wire logic TX_START_I,
   input wire logic [1:0] TX_CLASS_I,
   input wire logic [5:0] TX_CODE_I,
   input wire logic [4:0] TX_LEN_I,
   output logic TX_BUSY_O,
   output logic ACK_PENDING_O,
   output logic ACK_LATE_O,
   output logic RX_DROP_O
);
   // ------------------------------------------------------------
   // shared helpers
   // ------------------------------------------------------------
   function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      r = c ^ {8'h00, d};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   function automatic logic [15:0] crc_out(input logic [15:0] c);
      return CRC_INV ? ~c : c;
   endfunction

   // ------------------------------------------------------------
   // baud select and uart bit timing
   // ------------------------------------------------------------
   logic fast_reg, fast_next;
   logic [15:0] bit_cyc;
   assign bit_cyc = fast_reg ? host_packet_framer_pkg::BIT_CYC_FAST
                             : host_packet_framer_pkg::BIT_CYC_SLOW;
   assign FAST_BAUD_O = fast_reg;
   // switch only when transmitter idle so the answer leaves at the old rate
   logic tx_idle;
   always_comb begin
      fast_next = fast_reg;
      if (FAST_BAUD_REQ_I && tx_idle) begin
         fast_next = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // uart receiver, 8N1
   // ------------------------------------------------------------
   logic [15:0] rx_cnt_reg, rx_cnt_next;
   logic [3:0] rx_bit_reg, rx_bit_next;
   logic [7:0] rx_sh_reg, rx_sh_next;
   logic rx_busy_reg, rx_busy_next;
   logic rx_byte_stb;
   always_comb begin
      rx_cnt_next = rx_cnt_reg;
      rx_bit_next = rx_bit_reg;
      rx_sh_next = rx_sh_reg;
      rx_busy_next = rx_busy_reg;
      rx_byte_stb = 1'b0;
      if (!rx_busy_reg) begin
         if (!RXD_I) begin
            rx_busy_next = 1'b1;
            rx_cnt_next = bit_cyc >> 1;
            rx_bit_next = '0;
         end
      end else if (rx_cnt_reg != '0) begin
         rx_cnt_next = rx_cnt_reg - 16'h0001;
      end else begin
         rx_cnt_next = bit_cyc - 16'h0001;
         rx_bit_next = rx_bit_reg + 4'h1;
         if (rx_bit_reg == 4'h0 && RXD_I) begin
            rx_busy_next = 1'b0; // false start
         end else if (rx_bit_reg == 4'(host_packet_framer_pkg::DATA_BITS + 1)) begin
            rx_busy_next = 1'b0;
            rx_byte_stb = RXD_I; // framing error drops byte
         end else if (rx_bit_reg != 4'h0) begin
            rx_sh_next = {RXD_I, rx_sh_reg[7:1]};
         end
      end
   end

   // ------------------------------------------------------------
   // packet detector: buffer candidate, release only if valid
   // ------------------------------------------------------------
   logic [7:0] pbuf_reg [22];
   logic [4:0] rcnt_reg, rcnt_next;
   logic [15:0] rcrc_reg, rcrc_next;
   logic [4:0] dcnt_reg, dcnt_next;
   logic [4:0] dlen_reg, dlen_next;
   logic ddraining_reg, ddraining_next;
   logic drop_reg, drop_next;
   logic pend_reg, pend_next;
   logic [5:0] pend_code_reg, pend_code_next;
   logic [7:0] rx_wr_data;
   logic rx_wr;
   logic [4:0] rx_len_f;
   assign rx_len_f = 5'(pbuf_reg[1]);
   always_comb begin
      rcnt_next = rcnt_reg;
      rcrc_next = rcrc_reg;
      dcnt_next = dcnt_reg;
      dlen_next = dlen_reg;
      ddraining_next = ddraining_reg;
      drop_next = 1'b0;
      rx_wr = 1'b0;
      rx_wr_data = rx_sh_reg;
      if (ddraining_reg) begin
         if (RX_READY_I) begin
            dcnt_next = dcnt_reg + 5'h01;
            if (dcnt_reg == dlen_reg) begin
               ddraining_next = 1'b0;
            end
         end
      end else if (rx_byte_stb) begin
         rx_wr = 1'b1;
         rcnt_next = rcnt_reg + 5'h01;
         if (rcnt_reg < 5'h02 || rcnt_reg < rx_len_f + 5'h02) begin
            rcrc_next = crc_byte(rcrc_reg, rx_sh_reg);
         end
         if (rcnt_reg == 5'h01 && rx_sh_reg > host_packet_framer_pkg::MAX_LEN) begin
            rcnt_next = '0;
            rcrc_next = CRC_INIT;
            drop_next = 1'b1;
         end else if (rcnt_reg >= 5'h03 && rcnt_reg == rx_len_f + 5'h03) begin
            rcnt_next = '0;
            rcrc_next = CRC_INIT;
            // crc arrives low byte first
            if ({rx_sh_reg, pbuf_reg[rcnt_reg - 5'h01]} == crc_out(rcrc_reg)) begin
               ddraining_next = 1'b1;
               dcnt_next = '0;
               dlen_next = rx_len_f + 5'h01;
            end else begin
               drop_next = 1'b1;
            end
         end
      end
   end
   // the core sees type, length and payload of a good packet only
   assign RX_VALID_O = ddraining_reg;
   assign RX_DATA_O = pbuf_reg[dcnt_reg];
   assign RX_FIRST_O = ddraining_reg && dcnt_reg == 5'h00;
   assign RX_LAST_O = ddraining_reg && dcnt_reg == dlen_reg;
   assign RX_DROP_O = drop_reg;

   // ------------------------------------------------------------
   // answer deadline tracking
   // ------------------------------------------------------------
   logic [31:0] ack_cnt_reg, ack_cnt_next;
   logic late_reg, late_next;
   logic tx_start_ok;
   always_comb begin
      pend_next = pend_reg;
      pend_code_next = pend_code_reg;
      ack_cnt_next = ack_cnt_reg;
      late_next = late_reg;
      if (pend_reg && ack_cnt_reg != '0) begin
         ack_cnt_next = ack_cnt_reg - 32'h1;
      end
      if (pend_reg && ack_cnt_reg == 32'h1) begin
         late_next = 1'b1;
      end
      if (tx_start_ok && TX_CLASS_I[0]) begin
         pend_next = 1'b0; // response or error closes the wait
         late_next = 1'b0;
      end
      if (RX_FIRST_O && RX_READY_I) begin
         pend_next = 1'b1; // new packet wins over a close
         pend_code_next = RX_DATA_O[5:0];
         ack_cnt_next = 32'(ACK_CYCLES);
         late_next = 1'b0;
      end
   end
   assign ACK_PENDING_O = pend_reg;
   assign ACK_LATE_O = late_reg;

   // ------------------------------------------------------------
   // transmit path through payload fifo
   // ------------------------------------------------------------
   logic f_valid, f_ready;
   logic [7:0] f_data;
   pkt_fifo #(.WIDTH(8), .DEPTH(host_packet_framer_pkg::FIFO_DEPTH)) u_fifo (
      .clk_i(REF_CLK_I),
      .rst_i(SYS_RST_I),
      .in_valid_i(TX_VALID_I),
      .in_ready_o(TX_READY_O),
      .in_data_i(TX_DATA_I),
      .out_valid_o(f_valid),
      .out_ready_i(f_ready),
      .out_data_o(f_data)
   );

   typedef enum logic [4:0] {
      TS_IDLE = 5'h01,
      TS_TYPE = 5'h02,
      TS_LEN = 5'h04,
      TS_DATA = 5'h08,
      TS_CRC = 5'h10
   } tx_state_t;
   tx_state_t ts_reg, ts_next;
   logic [7:0] ttype_reg, ttype_next;
   logic [4:0] tlen_reg, tlen_next, tidx_reg, tidx_next;
   logic [15:0] tcrc_reg, tcrc_next;
   logic [7:0] tsh_reg, tsh_next;
   logic [15:0] tcnt_reg, tcnt_next;
   logic [3:0] tbit_reg, tbit_next;
   logic tline_reg, tline_next, tbusy_reg, tbusy_next;
   logic byte_load;
   logic [7:0] byte_val;
   logic [15:0] tcrc_fin;
   assign tcrc_fin = crc_out(tcrc_reg);

   assign tx_idle = (ts_reg == TS_IDLE) && !tbusy_reg;
   // reports may start whenever the transmitter is idle, even while an answer is awaited
   assign tx_start_ok = TX_START_I && tx_idle;
   assign TX_BUSY_O = !tx_idle;
   assign TXD_O = tline_reg;

   always_comb begin
      ts_next = ts_reg;
      ttype_next = ttype_reg;
      tlen_next = tlen_reg;
      tidx_next = tidx_reg;
      tcrc_next = tcrc_reg;
      byte_load = 1'b0;
      byte_val = 8'h00;
      f_ready = 1'b0;
      case (ts_reg)
         TS_IDLE: begin
            if (tx_start_ok) begin
               // answers reuse the pending command code
               ttype_next = {TX_CLASS_I, TX_CLASS_I[0] ? pend_code_reg : TX_CODE_I};
               tlen_next = (TX_LEN_I > 5'(host_packet_framer_pkg::MAX_LEN))
                           ? 5'(host_packet_framer_pkg::MAX_LEN) : TX_LEN_I;
               tcrc_next = CRC_INIT;
               ts_next = TS_TYPE;
            end
         end
         TS_TYPE: begin
            if (!tbusy_reg) begin
               byte_load = 1'b1;
               byte_val = ttype_reg;
               tcrc_next = crc_byte(tcrc_reg, ttype_reg);
               ts_next = TS_LEN;
            end
         end
         TS_LEN: begin
            if (!tbusy_reg) begin
               byte_load = 1'b1;
               byte_val = 8'(tlen_reg);
               tcrc_next = crc_byte(tcrc_reg, 8'(tlen_reg));
               tidx_next = '0;
               ts_next = (tlen_reg == '0) ? TS_CRC : TS_DATA;
            end
         end
         TS_DATA: begin
            if (!tbusy_reg && f_valid) begin
               f_ready = 1'b1;
               byte_load = 1'b1;
               byte_val = f_data;
               tcrc_next = crc_byte(tcrc_reg, f_data);
               tidx_next = tidx_reg + 5'h01;
               if (tidx_reg + 5'h01 == tlen_reg) begin
                  ts_next = TS_CRC;
                  tidx_next = '0;
               end
            end
         end
         TS_CRC: begin
            if (!tbusy_reg) begin
               byte_load = 1'b1;
               byte_val = tidx_reg[0] ? tcrc_fin[15:8] : tcrc_fin[7:0];
               tidx_next = tidx_reg + 5'h01;
               if (tidx_reg[0]) begin
                  ts_next = TS_IDLE;
               end
            end
         end
         default: ts_next = TS_IDLE;
      endcase
   end

   // uart transmitter: start, 8 data lsb first, one stop
   always_comb begin
      tsh_next = tsh_reg;
      tcnt_next = tcnt_reg;
      tbit_next = tbit_reg;
      tline_next = tline_reg;
      tbusy_next = tbusy_reg;
      if (byte_load) begin
         tsh_next = byte_val;
         tline_next = 1'b0;
         tcnt_next = bit_cyc - 16'h0001;
         tbit_next = '0;
         tbusy_next = 1'b1;
      end else if (tbusy_reg) begin
         if (tcnt_reg != '0) begin
            tcnt_next = tcnt_reg - 16'h0001;
         end else begin
            tcnt_next = bit_cyc - 16'h0001;
            tbit_next = tbit_reg + 4'h1;
            if (tbit_reg < 4'(host_packet_framer_pkg::DATA_BITS)) begin
               tline_next = tsh_reg[0];
               tsh_next = tsh_reg >> 1;
            end else if (tbit_reg < 4'(host_packet_framer_pkg::DATA_BITS
                                       + host_packet_framer_pkg::STOP_BITS)) begin
               tline_next = 1'b1;
            end else begin
               tbusy_next = 1'b0;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         fast_reg <= 1'b0;
         rx_cnt_reg <= '0;
         rx_bit_reg <= '0;
         rx_sh_reg <= '0;
         rx_busy_reg <= 1'b0;
         rcnt_reg <= '0;
         rcrc_reg <= CRC_INIT;
         dcnt_reg <= '0;
         dlen_reg <= '0;
         ddraining_reg <= 1'b0;
         drop_reg <= 1'b0;
         pend_reg <= 1'b0;
         pend_code_reg <= '0;
         ack_cnt_reg <= '0;
         late_reg <= 1'b0;
         ts_reg <= TS_IDLE;
         ttype_reg <= '0;
         tlen_reg <= '0;
         tidx_reg <= '0;
         tcrc_reg <= CRC_INIT;
         tsh_reg <= '0;
         tcnt_reg <= '0;
         tbit_reg <= '0;
         tline_reg <= 1'b1;
         tbusy_reg <= 1'b0;
      end else begin
         fast_reg <= fast_next;
         rx_cnt_reg <= rx_cnt_next;
         rx_bit_reg <= rx_bit_next;
         rx_sh_reg <= rx_sh_next;
         rx_busy_reg <= rx_busy_next;
         rcnt_reg <= rcnt_next;
         rcrc_reg <= rcrc_next;
         dcnt_reg <= dcnt_next;
         dlen_reg <= dlen_next;
         ddraining_reg <= ddraining_next;
         drop_reg <= drop_next;
         pend_reg <= pend_next;
         pend_code_reg <= pend_code_next;
         ack_cnt_reg <= ack_cnt_next;
         late_reg <= late_next;
         ts_reg <= ts_next;
         ttype_reg <= ttype_next;
         tlen_reg <= tlen_next;
         tidx_reg <= tidx_next;
         tcrc_reg <= tcrc_next;
         tsh_reg <= tsh_next;
         tcnt_reg <= tcnt_next;
         tbit_reg <= tbit_next;
         tline_reg <= tline_next;
         tbusy_reg <= tbusy_next;
      end
      if (rx_wr) begin
         pbuf_reg[rcnt_reg] <= rx_wr_data;
      end
   end
endmodule

// *** rtl/host_packet_framer_pkg.sv ***
// Purpose: shared constants for the host packet framer
// Assumes: 200 MHz system clock
// Notes: crc settings are parameters of the top module
package host_packet_framer_pkg;

   // ------------------------------------------------------------
   // link timing
   // ------------------------------------------------------------
   localparam int CLK_HZ = 200000000;
   localparam int BAUD_SLOW = 19200;
   localparam int BAUD_FAST = 115200;
   // bit period rounded down so the frame never runs long
   localparam logic [15:0] BIT_CYC_SLOW = 16'(CLK_HZ / BAUD_SLOW);
   localparam logic [15:0] BIT_CYC_FAST = 16'(CLK_HZ / BAUD_FAST);
   localparam int DATA_BITS = 8;
   localparam int STOP_BITS = 1;
   localparam int ACK_TIME_MS = 250;
   localparam longint ACK_CYC = longint'(CLK_HZ) / 1000 * ACK_TIME_MS;

   // ------------------------------------------------------------
   // packet format
   // ------------------------------------------------------------
   localparam logic [1:0] CLASS_CMD = 2'h0;
   localparam logic [1:0] CLASS_RESP = 2'h1;
   localparam logic [1:0] CLASS_REPORT = 2'h2;
   localparam logic [1:0] CLASS_ERROR = 2'h3;
   localparam logic [7:0] MAX_LEN = 8'h12;
   localparam int CODE_BITS = 6;
   localparam int FIFO_DEPTH = 4;

   // ------------------------------------------------------------
   // crc defaults
   // ------------------------------------------------------------
   localparam logic [15:0] CRC_POLY_DEF = 16'h8408;
   localparam logic [15:0] CRC_INIT_DEF = 16'hFFFF;
   localparam logic CRC_INV_DEF = 1'b1;

endpackage

// *** verification/host_link_model.sv ***
// Purpose: host end of the serial link
// Assumes: host knows the rate it commanded
// Notes: decodes only at the fast rate; slow frames are left to the bench
`timescale 1ns/10ps
module host_link_model (
   input wire logic clk_i,
   input wire logic txd_i,
   input wire logic fast_i,
   output logic rxd_o
);
   logic [7:0] rx_q[$];
   int bc;
   always_comb bc = fast_i ? int'(host_packet_framer_pkg::BIT_CYC_FAST) :
      int'(host_packet_framer_pkg::BIT_CYC_SLOW);
   initial rxd_o = 1'b1;
   // start bit, eight data bits lsb first, one stop bit
   task automatic send_byte(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         rxd_o = f[i];
         repeat (bc) @(posedge clk_i);
         #1;
      end
   endtask
   // every byte is queued; a bad stop bit queues unknown so it cannot match
   initial begin : rx_loop
      logic [7:0] b;
      forever begin
         @(negedge txd_i iff fast_i);
         repeat (bc / 2) @(posedge clk_i);
         for (int i = 0; i < 8; i++) begin
            repeat (bc) @(posedge clk_i);
            b[i] = txd_i;
         end
         repeat (bc) @(posedge clk_i);
         rx_q.push_back(txd_i === 1'b1 ? b : 8'hXX);
      end
   end
endmodule

// *** verification/host_packet_framer_checker.sv ***
// Purpose: port assertions for the host packet framer
// Assumes: one clock, synchronous active-high reset
// Notes: bound into every framer instance
`timescale 1ns/10ps
module host_packet_framer_checker #(
   parameter longint ACK_CYCLES = host_packet_framer_pkg::ACK_CYC
) (
   input wire logic REF_CLK_I,
   input wire logic SYS_RST_I,
   input wire logic TXD_O,
   input wire logic FAST_BAUD_REQ_I,
   input wire logic FAST_BAUD_O,
   input wire logic RX_VALID_O,
   input wire logic [7:0] RX_DATA_O,
   input wire logic RX_FIRST_O,
   input wire logic RX_LAST_O,
   input wire logic RX_READY_I,
   input wire logic TX_START_I,
   input wire logic TX_BUSY_O,
   input wire logic ACK_PENDING_O,
   input wire logic ACK_LATE_O,
   input wire logic RX_DROP_O
);
   logic [31:0] wait_reg;
   default clocking @(posedge REF_CLK_I); endclocking
   default disable iff (SYS_RST_I);
   // saturates so a stuck pending flag cannot wrap the count; a new packet restarts it
   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I || !ACK_PENDING_O || (RX_VALID_O && RX_FIRST_O && RX_READY_I)) begin
         wait_reg <= 32'h0;
      end else if (wait_reg != 32'hFFFFFFFF) begin
         wait_reg <= wait_reg + 32'h1;
      end
   end
   line_idle_a: assert property (!TX_BUSY_O |-> TXD_O)
      else $error("serial out low while idle");
   start_bit_a: assert property (TX_START_I && !TX_BUSY_O |=> TX_BUSY_O ##1 !TXD_O)
      else $error("start bit not two cycles after start");
   rx_hold_a: assert property (RX_VALID_O && !RX_READY_I |=> RX_VALID_O
      && $stable(RX_DATA_O) && $stable(RX_FIRST_O) && $stable(RX_LAST_O))
      else $error("offered byte changed before taken");
   drop_pulse_a: assert property (RX_DROP_O |=> !RX_DROP_O)
      else $error("drop pulse longer than one cycle");
   pend_set_a: assert property (RX_VALID_O && RX_FIRST_O && RX_READY_I |=> ACK_PENDING_O)
      else $error("received packet not pending");
   late_flag_a: assert property (ACK_PENDING_O && longint'(wait_reg) >= ACK_CYCLES + 2
      |-> ACK_LATE_O)
      else $error("late answer not flagged");
   fast_keep_a: assert property (FAST_BAUD_O |=> FAST_BAUD_O)
      else $error("fast rate dropped");
   fast_take_a: assert property (FAST_BAUD_REQ_I && !TX_BUSY_O |-> ##[0:2] FAST_BAUD_O)
      else $error("fast rate request ignored");
endmodule
bind host_packet_framer host_packet_framer_checker #(.ACK_CYCLES(ACK_CYCLES)) chk (
   .REF_CLK_I(REF_CLK_I), .SYS_RST_I(SYS_RST_I), .TXD_O(TXD_O),
   .FAST_BAUD_REQ_I(FAST_BAUD_REQ_I), .FAST_BAUD_O(FAST_BAUD_O), .RX_VALID_O(RX_VALID_O),
   .RX_DATA_O(RX_DATA_O), .RX_FIRST_O(RX_FIRST_O), .RX_LAST_O(RX_LAST_O),
   .RX_READY_I(RX_READY_I), .TX_START_I(TX_START_I), .TX_BUSY_O(TX_BUSY_O),
   .ACK_PENDING_O(ACK_PENDING_O), .ACK_LATE_O(ACK_LATE_O), .RX_DROP_O(RX_DROP_O));

// *** verification/tb_top.sv ***
// Purpose: self-checking bench for the host packet framer
// Assumes: ack limit shortened to 2000 cycles
// Notes: slow rate is checked on one start bit, then aborted by reset
`timescale 1ns/10ps
module tb_top;
   typedef logic [7:0] byte_q_t[$];
   logic REF_CLK_I, SYS_RST_I, RXD_I, TXD_O, FAST_BAUD_REQ_I, FAST_BAUD_O;
   logic RX_VALID_O, RX_FIRST_O, RX_LAST_O, RX_READY_I, TX_VALID_I, TX_READY_O;
   logic TX_START_I, TX_BUSY_O, ACK_PENDING_O, ACK_LATE_O, RX_DROP_O;
   logic [7:0] RX_DATA_O, TX_DATA_I;
   logic [1:0] TX_CLASS_I;
   logic [5:0] TX_CODE_I, cmd_code, rep_code;
   logic [4:0] TX_LEN_I;
   logic [9:0] got_q[$];
   byte_q_t pay_q;
   int error_cnt = 0;
   int checks = 0;
   int seed = 32'h1596;
   int drops = 0;
   int n;

   host_packet_framer #(.ACK_CYCLES(2000)) DUT (
      .REF_CLK_I(REF_CLK_I), .SYS_RST_I(SYS_RST_I), .RXD_I(RXD_I), .TXD_O(TXD_O),
      .FAST_BAUD_REQ_I(FAST_BAUD_REQ_I), .FAST_BAUD_O(FAST_BAUD_O),
      .RX_VALID_O(RX_VALID_O), .RX_DATA_O(RX_DATA_O), .RX_FIRST_O(RX_FIRST_O),
      .RX_LAST_O(RX_LAST_O), .RX_READY_I(RX_READY_I), .TX_VALID_I(TX_VALID_I),
      .TX_DATA_I(TX_DATA_I), .TX_READY_O(TX_READY_O), .TX_START_I(TX_START_I),
      .TX_CLASS_I(TX_CLASS_I), .TX_CODE_I(TX_CODE_I), .TX_LEN_I(TX_LEN_I),
      .TX_BUSY_O(TX_BUSY_O), .ACK_PENDING_O(ACK_PENDING_O), .ACK_LATE_O(ACK_LATE_O),
      .RX_DROP_O(RX_DROP_O));
   host_link_model LINK (.clk_i(REF_CLK_I), .txd_i(TXD_O), .fast_i(FAST_BAUD_O), .rxd_o(RXD_I));

   // ------------------------------------------------------------
   // expectations and checks
   // ------------------------------------------------------------
   function automatic byte_q_t framed(input logic [7:0] ty, input byte_q_t pl);
      byte_q_t q;
      logic [15:0] c;
      q = {ty, 8'(pl.size())};
      q = {q, pl};
      c = host_packet_framer_pkg::CRC_INIT_DEF;
      foreach (q[i]) begin
         c = c ^ {8'h00, q[i]};
         for (int k = 0; k < 8; k++) begin
            c = c[0] ? ((c >> 1) ^ host_packet_framer_pkg::CRC_POLY_DEF) : (c >> 1);
         end
      end
      c = host_packet_framer_pkg::CRC_INV_DEF ? ~c : c;
      q.push_back(c[7:0]);
      q.push_back(c[15:8]);
      return q;
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // drivers
   // ------------------------------------------------------------
   task automatic start_tx(input logic [1:0] cls, input logic [5:0] code, input logic [4:0] len);
      TX_CLASS_I = cls;
      TX_CODE_I = code;
      TX_LEN_I = len;
      TX_START_I = 1'b1;
      @(posedge REF_CLK_I);
      #1;
      TX_START_I = 1'b0;
   endtask

   // valid stays up between pushes; the caller lowers it
   task automatic push_fifo(input logic [7:0] b);
      TX_VALID_I = 1'b1;
      TX_DATA_I = b;
      @(posedge REF_CLK_I);
      while (TX_READY_O !== 1'b1) @(posedge REF_CLK_I);
      #1;
   endtask

   task automatic host_send(input byte_q_t q);
      foreach (q[i]) LINK.send_byte(q[i]);
   endtask

   task automatic expect_tx(input byte_q_t q);
      n = 0;
      while (LINK.rx_q.size() < q.size() && n < 200000) begin
         @(posedge REF_CLK_I);
         n++;
      end
      chk(32'(LINK.rx_q.size()), 32'(q.size()), "serial out count");
      foreach (q[i]) chk(32'(LINK.rx_q.pop_front()), 32'(q[i]), "serial out byte");
   endtask

   // ------------------------------------------------------------
   // clock, watchdog, core side
   // ------------------------------------------------------------
   initial begin
      REF_CLK_I = 1'b0;
      forever #2.5 REF_CLK_I = ~REF_CLK_I;
   end
   initial begin
      #2000000;
      error_cnt++;
      $display("ERROR at %0t: watchdog expired", $time);
      stop_test();
   end
   // core stalls at random so offered bytes must wait
   always @(posedge REF_CLK_I) begin
      #1 RX_READY_I = 1'($random(seed));
   end
   always @(posedge REF_CLK_I) begin
      if (SYS_RST_I === 1'b0 && RX_VALID_O === 1'b1 && RX_READY_I === 1'b1) begin
         got_q.push_back({RX_FIRST_O, RX_LAST_O, RX_DATA_O});
      end
      if (SYS_RST_I === 1'b0 && RX_DROP_O === 1'b1) begin
         drops++;
      end
   end

   initial begin
      {SYS_RST_I, FAST_BAUD_REQ_I, TX_VALID_I, TX_START_I} = 4'h8;
      {TX_DATA_I, TX_CLASS_I, TX_CODE_I, TX_LEN_I, RX_READY_I} = 22'h0;
      repeat (3) @(posedge REF_CLK_I);
      #1 SYS_RST_I = 1'b0;
      chk(32'(TXD_O), 32'h1, "idle line");
      // type lsb is one, so the first low run is exactly the start bit
      start_tx(host_packet_framer_pkg::CLASS_REPORT, 6'h01, 5'h00);
      n = 0;
      while (TXD_O !== 1'b0 && n < 100) begin
         @(posedge REF_CLK_I) #1;
         n++;
      end
      n = 0;
      while (TXD_O === 1'b0 && n < 20000) begin
         @(posedge REF_CLK_I) #1;
         n++;
      end
      chk(32'(n), 32'(host_packet_framer_pkg::BIT_CYC_SLOW), "slow bit time");
      SYS_RST_I = 1'b1;
      FAST_BAUD_REQ_I = 1'b1;
      repeat (3) @(posedge REF_CLK_I);
      #1 SYS_RST_I = 1'b0;
      repeat (3) @(posedge REF_CLK_I);
      #1 chk(32'(FAST_BAUD_O), 32'h1, "fast rate");
      chk(32'(TXD_O), 32'h1, "line after abort");
      cmd_code = 6'($random(seed));
      rep_code = 6'($random(seed));
      fork
         host_send(framed({host_packet_framer_pkg::CLASS_CMD, cmd_code}, pay_q));
         begin
            start_tx(host_packet_framer_pkg::CLASS_REPORT, rep_code, 5'h00);
            expect_tx(framed({host_packet_framer_pkg::CLASS_REPORT, rep_code}, pay_q));
         end
      join
      n = 0;
      while (got_q.size() < 2 && n < 1000) begin
         @(posedge REF_CLK_I) #1;
         n++;
      end
      chk(32'(got_q[0]), 32'({2'b10, host_packet_framer_pkg::CLASS_CMD, cmd_code}), "type");
      chk(32'(got_q[1]), 32'h100, "length");
      chk(32'(ACK_PENDING_O), 32'h1, "pending");
      repeat (2100) @(posedge REF_CLK_I);
      #1 chk(32'(ACK_LATE_O), 32'h1, "late flag");
      got_q = {};
      for (int i = 0; i < 4; i++) pay_q.push_back(8'($random(seed)));
      fork
         begin
            foreach (pay_q[i]) push_fifo(pay_q[i]);
            TX_VALID_I = 1'b1;
            repeat (2) @(posedge REF_CLK_I);
            #1 chk(32'(TX_READY_O), 32'h0, "full fifo");
            TX_VALID_I = 1'b0;
            start_tx(host_packet_framer_pkg::CLASS_RESP, ~cmd_code, 5'h04);
            expect_tx(framed({host_packet_framer_pkg::CLASS_RESP, cmd_code}, pay_q));
            chk(32'(ACK_PENDING_O), 32'h0, "answered");
         end
         host_send({8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h13});
      join
      chk(32'(drops >= 2), 32'h1, "drops");
      chk(32'(got_q.size()), 32'h0, "nothing offered");
      stop_test();
   end
endmodule
